//--- hw/counter_readback_status_latch.sv
// Three 16-bit down counters with count latch, status latch and readback.
// Assumes a host bus with single-cycle read and write strobes on ref_clk.
`timescale 1ns/1ps
module counter_readback_status_latch (
	input wire logic ref_clk, // 100 MHz system clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire timer_readback_pkg::io_req_t bus, // Host access strobes.
	output logic [7:0] rdata, // Read data, valid after a read.
	input wire logic count_clk_0, // Counter 0 count clock pin.
	input wire logic count_clk_2, // Counter 2 count clock pin.
	input wire logic [2:0] gate_in, // Gate pins, high enables.
	output logic [2:0] out_level, // Counter output pins.
	output logic fixed_clk_out // Fixed 1 MHz clock out.
);
	localparam int N = timer_readback_pkg::NUM_COUNTERS;

	logic [1:0] clk_sync;
	logic [2:0] gate_sync;
	logic [1:0] clk_prev_ff;
	logic [5:0] div_cnt_ff;
	logic fixed_clk_ff;
	logic fixed_rise;
	logic [2:0] count_edge;
	logic [7:0] rdata_ff;

	sync_two_flop #(.WIDTH(2)) u_clk_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.din({count_clk_2, count_clk_0}),
		.dout(clk_sync)
	);

	sync_two_flop #(.WIDTH(3)) u_gate_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.din(gate_in),
		.dout(gate_sync)
	);

	// Divider for the fixed clock; it drives counter 1 and the pin.
	assign fixed_rise = (div_cnt_ff == timer_readback_pkg::DIV_LAST) &&
		!fixed_clk_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_cnt_ff <= '0;
			fixed_clk_ff <= 1'b0;
			clk_prev_ff <= '0;
		end else begin
			clk_prev_ff <= clk_sync;
			if (div_cnt_ff == timer_readback_pkg::DIV_LAST) begin
				div_cnt_ff <= '0;
				fixed_clk_ff <= !fixed_clk_ff;
			end else begin
				div_cnt_ff <= div_cnt_ff + 6'h01;
			end
		end
	end

	assign fixed_clk_out = fixed_clk_ff;
	assign count_edge[0] = clk_sync[0] && !clk_prev_ff[0];
	assign count_edge[1] = fixed_rise;
	assign count_edge[2] = clk_sync[1] && !clk_prev_ff[1];

	// Command decode shared by all counters.
	wire ctrl_wr = bus.wr && (bus.addr == timer_readback_pkg::ADDR_CTRL);
	wire [1:0] sc_field = bus.wdata[timer_readback_pkg::CTRL_SC_HI:
		timer_readback_pkg::CTRL_SC_LO];
	wire [1:0] rw_field = bus.wdata[timer_readback_pkg::CTRL_RW_HI:
		timer_readback_pkg::CTRL_RW_LO];
	wire is_readback = ctrl_wr && (sc_field == timer_readback_pkg::SC_READBACK);
	wire rb_cnt_n = bus.wdata[timer_readback_pkg::RB_CNT_BIT];
	wire rb_sta_n = bus.wdata[timer_readback_pkg::RB_STA_BIT];

	logic [7:0] rd_byte [N];

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ch
			logic [2:0] mode_ff;
			logic [1:0] fmt_ff;
			logic bcd_ff;
			logic out_ff;
			logic null_ff;
			logic load_pend_ff;
			logic armed_ff;
			logic [15:0] count_reg_ff;
			logic [15:0] ce_ff;
			logic [15:0] hold_ff;
			logic latched_ff;
			timer_readback_pkg::counter_status_snapshot_t snap_ff;
			logic sta_pend_ff;
			logic rd_hi_ff;
			logic wr_hi_ff;
			timer_readback_pkg::counter_status_snapshot_t status_now;

			wire here = (bus.addr == 2'(i));
			wire sel_ctrl = ctrl_wr && !is_readback && (sc_field == 2'(i));
			wire rb_sel = is_readback &&
				bus.wdata[timer_readback_pkg::RB_SEL_LO + i];
			wire prog = sel_ctrl && (rw_field != timer_readback_pkg::RW_LATCH);
			wire cnt_cmd = (sel_ctrl &&
				(rw_field == timer_readback_pkg::RW_LATCH)) ||
				(rb_sel && !rb_cnt_n);
			wire sta_cmd = rb_sel && !rb_sta_n;
			wire data_wr = bus.wr && here;
			wire data_rd = bus.rd && here;
			wire is_word = (fmt_ff == timer_readback_pkg::RW_WORD);
			wire take_hi = (fmt_ff == timer_readback_pkg::RW_MSB) ||
				(is_word && rd_hi_ff);
			wire [15:0] src = latched_ff ? hold_ff : ce_ff;
			wire read_done = !is_word || rd_hi_ff;
			wire tc = (ce_ff == timer_readback_pkg::TC_VALUE);
			wire periodic = mode_ff[timer_readback_pkg::MODE_PERIODIC_BIT];

			assign status_now = '{
				out_level: out_ff,
				null_count: null_ff,
				access_format_hi: fmt_ff[1],
				access_format_lo: fmt_ff[0],
				mode_sel_2: mode_ff[2],
				mode_sel_1: mode_ff[1],
				mode_sel_0: mode_ff[0],
				bcd: bcd_ff
			};

			// Pending status wins over held count bytes.
			assign rd_byte[i] = sta_pend_ff ? snap_ff :
				(take_hi ? src[15:8] : src[7:0]);
			assign out_level[i] = out_ff;

			always_ff @(posedge ref_clk) begin
				if (rst) begin
					mode_ff <= timer_readback_pkg::MODE_TERMINAL;
					fmt_ff <= timer_readback_pkg::FMT_RESET;
					bcd_ff <= 1'b0;
					out_ff <= 1'b0;
					null_ff <= 1'b0;
					load_pend_ff <= 1'b0;
					armed_ff <= 1'b0;
					count_reg_ff <= timer_readback_pkg::COUNT_RESET;
					ce_ff <= timer_readback_pkg::COUNT_RESET;
					hold_ff <= timer_readback_pkg::COUNT_RESET;
					latched_ff <= 1'b0;
					snap_ff <= '0;
					sta_pend_ff <= 1'b0;
					rd_hi_ff <= 1'b0;
					wr_hi_ff <= 1'b0;
				end else if (prog) begin
					mode_ff <= bus.wdata[timer_readback_pkg::CTRL_MODE_HI:
						timer_readback_pkg::CTRL_MODE_LO];
					fmt_ff <= rw_field;
					bcd_ff <= bus.wdata[timer_readback_pkg::CTRL_BCD_BIT];
					out_ff <= (bus.wdata[timer_readback_pkg::CTRL_MODE_HI:
						timer_readback_pkg::CTRL_MODE_LO] !=
						timer_readback_pkg::MODE_TERMINAL);
					null_ff <= 1'b1;
					load_pend_ff <= 1'b0;
					armed_ff <= 1'b0;
					latched_ff <= 1'b0;
					sta_pend_ff <= 1'b0;
					rd_hi_ff <= 1'b0;
					wr_hi_ff <= 1'b0;
				end else begin
					// Counting element; a pending load is taken first.
					if (count_edge[i] && gate_sync[i]) begin
						if (load_pend_ff) begin
							ce_ff <= count_reg_ff;
							load_pend_ff <= 1'b0;
							null_ff <= 1'b0;
							armed_ff <= 1'b1;
						end else if (armed_ff) begin
							ce_ff <= ce_ff - 16'h0001;
							if (tc && mode_ff == timer_readback_pkg::MODE_TERMINAL) begin
								out_ff <= 1'b1;
							end else if (tc && periodic) begin
								ce_ff <= count_reg_ff;
								out_ff <= !out_ff;
							end
						end
					end
					// A new count write after the transfer sets null again.
					if (data_wr) begin
						unique case (fmt_ff)
							timer_readback_pkg::RW_LSB: begin
								count_reg_ff <= {timer_readback_pkg::BYTE_ZERO,
									bus.wdata};
								load_pend_ff <= 1'b1;
								null_ff <= 1'b1;
							end
							timer_readback_pkg::RW_MSB: begin
								count_reg_ff <= {bus.wdata,
									timer_readback_pkg::BYTE_ZERO};
								load_pend_ff <= 1'b1;
								null_ff <= 1'b1;
							end
							default: begin
								wr_hi_ff <= !wr_hi_ff;
								if (!wr_hi_ff) begin
									count_reg_ff[7:0] <= bus.wdata;
								end else begin
									count_reg_ff[15:8] <= bus.wdata;
									load_pend_ff <= 1'b1;
									null_ff <= 1'b1;
								end
							end
						endcase
					end
					if (cnt_cmd && !latched_ff) begin
						hold_ff <= ce_ff;
						latched_ff <= 1'b1;
					end
					if (sta_cmd && !sta_pend_ff) begin
						snap_ff <= status_now;
						sta_pend_ff <= 1'b1;
					end
					if (data_rd) begin
						if (sta_pend_ff) begin
							sta_pend_ff <= 1'b0;
						end else begin
							if (is_word) begin
								rd_hi_ff <= !rd_hi_ff;
							end
							if (latched_ff && read_done) begin
								latched_ff <= 1'b0;
							end
						end
					end
				end
			end
		end
	endgenerate

	// Read data is registered; the control location reads as zero.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_ff <= timer_readback_pkg::BYTE_ZERO;
		end else if (bus.rd) begin
			rdata_ff <= (bus.addr == timer_readback_pkg::ADDR_CTRL) ?
				timer_readback_pkg::BYTE_ZERO : rd_byte[bus.addr];
		end
	end

	assign rdata = rdata_ff;
endmodule

//--- shared/timer_readback_pkg.sv
// Constants and carrier types for the three-channel counter readback block.
// Assumes one 100 MHz clock and a host bus already synchronous to it.
package timer_readback_pkg;

	localparam int REF_CLK_HZ = 100_000_000;
	localparam int FIXED_CLK_HZ = 1_000_000;
	localparam int DIV_HALF_CYCLES = REF_CLK_HZ / (2 * FIXED_CLK_HZ);
	localparam logic [5:0] DIV_LAST = 6'(DIV_HALF_CYCLES - 1);

	localparam int NUM_COUNTERS = 3;
	localparam logic [1:0] ADDR_CTRL = 2'h3;
	localparam int FIXED_CLK_COUNTER = 1;

	// Control byte fields.
	localparam int CTRL_SC_HI = 7;
	localparam int CTRL_SC_LO = 6;
	localparam int CTRL_RW_HI = 5;
	localparam int CTRL_RW_LO = 4;
	localparam int CTRL_MODE_HI = 3;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_BCD_BIT = 0;
	localparam logic [1:0] SC_READBACK = 2'h3;

	// Readback command fields.
	localparam int RB_CNT_BIT = 5;
	localparam int RB_STA_BIT = 4;
	localparam int RB_SEL_LO = 1;

	// Access formats.
	localparam logic [1:0] RW_LATCH = 2'h0;
	localparam logic [1:0] RW_LSB = 2'h1;
	localparam logic [1:0] RW_MSB = 2'h2;
	localparam logic [1:0] RW_WORD = 2'h3;

	localparam logic [2:0] MODE_TERMINAL = 3'h0;
	localparam int MODE_PERIODIC_BIT = 1;
	localparam logic [15:0] TC_VALUE = 16'h0001;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [1:0] FMT_RESET = 2'h3;

	// Host access, one cycle strobes.
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} io_req_t;

	// Snapshot layout, bit 7 down to bit 0.
	typedef struct packed {
		logic out_level;
		logic null_count;
		logic access_format_hi;
		logic access_format_lo;
		logic mode_sel_2;
		logic mode_sel_1;
		logic mode_sel_0;
		logic bcd;
	} counter_status_snapshot_t;

endpackage

//--- hw/sync_two_flop.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes the levels are slow compared to the sampling clock.
`timescale 1ns/1ps
module sync_two_flop #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk, // Sampling clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [WIDTH-1:0] din, // Asynchronous levels.
	output logic [WIDTH-1:0] dout // Synchronised levels.
);
	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_ff <= '0;
			dout <= '0;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule

//--- dv/counter_readback_asserts.sv
// Port checker for the counter readback block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module counter_readback_asserts (
	input wire logic ref_clk, // Clock.
	input wire logic rst, // Reset, active high.
	input wire timer_readback_pkg::io_req_t bus, // Host strobes.
	input wire logic [7:0] rdata, // Read data.
	input wire logic [2:0] out_level, // Counter outputs.
	input wire logic fixed_clk_out // Fixed clock out.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_stat(int k);
		bus.wr && bus.addr == 2'h3 && bus.wdata[7:6] == 2'h3 &&
			!bus.wdata[4] && bus.wdata[k + 1];
	endsequence
	sequence s_rd(int k);
		bus.rd && bus.addr == 2'(k);
	endsequence
	property p_fix_hi;
		$rose(fixed_clk_out) |-> ##50 $fell(fixed_clk_out);
	endproperty
	property p_fix_lo;
		$fell(fixed_clk_out) |-> ##50 $rose(fixed_clk_out);
	endproperty
	property p_rst_idle;
		$fell(rst) |-> rdata == 8'h00 && out_level == 3'h0 && !fixed_clk_out;
	endproperty
	property p_hold;
		!bus.rd |=> $stable(rdata);
	endproperty
	property p_out0;
		s_stat(0) ##1 s_rd(0) |=> rdata[7] == $past(out_level[0], 2);
	endproperty
	property p_out2;
		s_stat(2) ##1 s_rd(2) |=> rdata[7] == $past(out_level[2], 2);
	endproperty
	property p_first;
		bus.wr && bus.addr == 2'h3 && bus.wdata == 8'h00 ##1 s_stat(0)
			##1 s_rd(0) |=> rdata[5:4] != 2'h0;
	endproperty
	property p_fmt;
		bus.wr && bus.addr == 2'h3 && bus.wdata[7:6] == 2'h2 &&
			bus.wdata[5:4] != 2'h0 ##1 s_stat(2) ##1 s_rd(2)
			|=> rdata[5:0] == $past(bus.wdata[5:0], 3);
	endproperty
	a_fix_hi: assert property (p_fix_hi) else $error("fixed clock high");
	a_fix_lo: assert property (p_fix_lo) else $error("fixed clock low");
	a_rst_idle: assert property (p_rst_idle) else $error("reset state");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_out0: assert property (p_out0) else $error("status out 0");
	a_out2: assert property (p_out2) else $error("status out 2");
	a_first: assert property (p_first) else $error("status not first");
	a_fmt: assert property (p_fmt) else $error("status fields");
endmodule
bind counter_readback_status_latch counter_readback_asserts chk_u (
	.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata),
	.out_level(out_level), .fixed_clk_out(fixed_clk_out));

//--- dv/host_model.sv
// Host processor model giving one-cycle strobes on the counter bus.
// Assumes its tasks are called at a falling clock edge.
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk, // Clock.
	input wire logic [7:0] rdata, // Read data.
	output timer_readback_pkg::io_req_t bus // Host strobes.
);
	initial bus = '0;
	task automatic acc(input logic [1:0] a, input logic [7:0] x,
		input logic w, input logic r);
		bus = '{addr: a, wdata: x, wr: w, rd: r};
		@(negedge ref_clk);
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] x);
		acc(a, x, 1'h1, 1'h0);
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] x);
		acc(a, ~bus.wdata, 1'h0, 1'h1);
		x = rdata;
	endtask
	task automatic readback(input logic cnt_n, input logic sta_n,
		input logic [2:0] sel);
		wr(2'h3, {2'h3, cnt_n, sta_n, sel, 1'h0});
	endtask
	task automatic idle();
		acc(~bus.addr, ~bus.wdata, 1'h0, 1'h0);
	endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the counter readback block.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic count_clk_0 = 1'h0;
	logic count_clk_2 = 1'h0;
	logic [2:0] gate_in = 3'h0;
	timer_readback_pkg::io_req_t bus;
	logic [7:0] rdata;
	logic [2:0] out_level;
	logic fixed_clk_out;
	logic [7:0] d;
	logic [7:0] c;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	int t;
	counter_readback_status_latch dut_u (.ref_clk(ref_clk), .rst(rst),
		.bus(bus), .rdata(rdata), .count_clk_0(count_clk_0),
		.count_clk_2(count_clk_2), .gate_in(gate_in),
		.out_level(out_level), .fixed_clk_out(fixed_clk_out));
	host_model host_u (.ref_clk(ref_clk), .rdata(rdata), .bus(bus));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic stop_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
		host_u.rd(a, d);
		chk(d, e);
	endtask
	// One rising edge on both count clocks, long enough for the sync.
	task automatic tick();
		{count_clk_2, count_clk_0} = 2'h3;
		repeat (4) host_u.idle();
		{count_clk_2, count_clk_0} = 2'h0;
		repeat (4) host_u.idle();
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'h0;
		host_u.wr(2'h3, 8'h30);
		host_u.wr(2'h0, 8'h08);
		host_u.wr(2'h0, 8'h12);
		host_u.readback(1'h1, 1'h0, 3'h1);
		host_u.rd(2'h0, d);
		chk(d & 8'h7F, 8'h70);
		rdchk(2'h0, 8'h00);
		rdchk(2'h0, 8'h00);
		gate_in = 3'h7;
		tick();
		host_u.wr(2'h3, 8'h00);
		tick();
		host_u.wr(2'h3, 8'h00);
		host_u.readback(1'h1, 1'h0, 3'h1);
		host_u.rd(2'h0, d);
		chk(d & 8'h7F, 8'h30);
		rdchk(2'h0, 8'h08);
		rdchk(2'h0, 8'h12);
		host_u.readback(1'h0, 1'h0, 3'h1);
		host_u.rd(2'h0, d);
		chk(d & 8'h7F, 8'h30);
		rdchk(2'h0, 8'h07);
		rdchk(2'h0, 8'h12);
		host_u.readback(1'h0, 1'h1, 3'h7);
		tick();
		rdchk(2'h0, 8'h07);
		rdchk(2'h0, 8'h12);
		rdchk(2'h0, 8'h06);
		rdchk(2'h0, 8'h12);
		rdchk(2'h1, 8'h00);
		rdchk(2'h2, 8'h00);
		for (int m = 0; m < 6; m++) begin
			c = {2'h2, 2'((m % 3) + 1), 3'(m), 1'(m)};
			host_u.wr(2'h3, c);
			host_u.readback(1'h1, 1'h0, 3'h4);
			host_u.rd(2'h2, d);
			chk(d & 8'h3F, c & 8'h3F);
		end
		host_u.wr(2'h3, 8'h70);
		host_u.wr(2'h1, 8'h03);
		host_u.wr(2'h1, 8'h00);
		repeat (700) host_u.idle();
		chk({7'h00, out_level[1]}, 8'h01);
		@(posedge fixed_clk_out);
		t = cycles;
		@(posedge fixed_clk_out);
		chk(8'(cycles - t), 8'h64);
		stop_test();
	end
endmodule
